// ===== hdl/pdu_framer_defs.vh
// constants of the convergence-layer packet framer
`ifndef PDU_FRAMER_DEFS_VH
`define PDU_FRAMER_DEFS_VH

// ----------------------------------------------------------------------------
// register word addresses
// ----------------------------------------------------------------------------
`define ADR_DEMAND_A   3'h0
`define ADR_DEMAND_IP  3'h1
`define ADR_CTRL       3'h2
`define ADR_STATUS     3'h3
`define ADR_ACCEPT_A   3'h4
`define ADR_ACCEPT_IP  3'h5
`define ADR_ACCEPT_B   3'h6
`define ADR_MTU        3'h7

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DA_CTX    3:0
`define DA_THIRD  7:4
`define DA_ADDRESS_TYPE_IN_DEMAND   10:8
`define DA_SIXTH  14:11
`define DA_HCNEG  22:15
`define DA_SLOTS  30:23
`define AA_CTX    3:0
`define AA_PMAX   6:4
`define AA_READY  10:7
`define AA_STBY   14:11
`define AA_RWAIT  18:15
`define AA_TIA    21:19
`define AB_HCNEG  7:0
`define AB_SLOTS  15:8
`define AB_MTU    18:16
`define CTRL_START 0
`define ST_ACCEPT  0
`define ST_MALFORM 1
`define ST_MTU     2
`define ST_DEMAND  3
`define ST_QFULL   4
`define ST_BUSY    8

// ----------------------------------------------------------------------------
// codes, reset values and limits
// ----------------------------------------------------------------------------
`define TYPE_ACCEPT  4'h1
`define TYPE_DEMAND  4'h0
`define PRIO_FIXED   3'h4
`define PMAX_RST     3'h0
`define MTU_RST      16'h05dc
`define OPT_MAX_BITS 11'h4bb

`endif

// ===== hdl/pdu_bit_shifter.v
// msb-first serialiser of one field at a time
`timescale 1ns/1ps
module pdu_bit_shifter (
  input  wire        clock_i,
  input  wire        sys_rst_i,
  input  wire        load_i,
  input  wire [31:0] value_i,
  input  wire [5:0]  width_i,
  input  wire        last_i,
  output wire        free_o,
  output wire        bit_o,
  output wire        valid_o,
  output wire        last_o
);
  reg [31:0] sh_reg;
  reg [5:0]  cnt_reg;
  reg        last_reg;

  assign free_o  = (cnt_reg <= 6'd1);
  assign bit_o   = sh_reg[31];
  assign valid_o = (cnt_reg != 6'd0);
  assign last_o  = last_reg && (cnt_reg == 6'd1);

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      sh_reg   <= 32'h0;
      cnt_reg  <= 6'h0;
      last_reg <= 1'b0;
    end else if (load_i) begin
      sh_reg   <= value_i << (6'd32 - width_i); // [R1]
      cnt_reg  <= width_i;
      last_reg <= last_i;
    end else if (cnt_reg != 6'd0) begin
      sh_reg  <= {sh_reg[30:0], 1'b0};
      cnt_reg <= cnt_reg - 6'd1;
    end
  end
endmodule // pdu_bit_shifter

// ===== hdl/prio_queue_set.v
// one fifo per priority level, highest non-empty level drains first
`timescale 1ns/1ps
module prio_queue_set #(
  parameter W     = 8,
  parameter DEPTH = 4,
  parameter AW    = 2
) (
  input  wire         clock_i,
  input  wire         sys_rst_i,
  input  wire         push_i,
  input  wire [2:0]   push_prio_i,
  input  wire [W-1:0] push_data_i,
  output wire         full_o,
  input  wire         pop_i,
  output reg          avail_o,
  output reg  [2:0]   top_prio_o,
  output wire [W-1:0] top_data_o
);
  localparam [AW:0] FULL_CNT = DEPTH;
  wire [7:0]     nonempty;
  wire [7:0]     full_vec;
  wire [8*W-1:0] head_flat;
  integer        i;

  assign full_o     = full_vec[push_prio_i];
  assign top_data_o = head_flat[top_prio_o*W +: W];

  always @* begin
    avail_o    = 1'b0;
    top_prio_o = 3'h0;
    for (i = 0; i < 8; i = i + 1) begin
      if (nonempty[i]) begin
        avail_o    = 1'b1;
        top_prio_o = i[2:0]; // [R3]
      end
    end
  end

  genvar q;
  generate
    for (q = 0; q < 8; q = q + 1) begin : lvl
      localparam [2:0] LVL = q;
      reg  [W-1:0]  mem [0:DEPTH-1];
      reg  [AW-1:0] wp_reg;
      reg  [AW-1:0] rp_reg;
      reg  [AW:0]   cnt_reg;
      wire          do_push = push_i && (push_prio_i == LVL) && (cnt_reg != FULL_CNT);
      wire          do_pop  = pop_i && avail_o && (top_prio_o == LVL);
      assign nonempty[q] = (cnt_reg != {(AW+1){1'b0}});
      assign full_vec[q] = (cnt_reg == FULL_CNT);
      assign head_flat[q*W +: W] = mem[rp_reg];
      always @(posedge clock_i) begin
        if (do_push) begin
          mem[wp_reg] <= push_data_i; // [R3]
        end
      end
      always @(posedge clock_i) begin
        if (sys_rst_i) begin
          wp_reg  <= {AW{1'b0}};
          rp_reg  <= {AW{1'b0}};
          cnt_reg <= {(AW+1){1'b0}};
        end else begin
          if (do_push) begin
            wp_reg <= wp_reg + {{(AW-1){1'b0}}, 1'b1};
          end
          if (do_pop) begin
            rp_reg <= rp_reg + {{(AW-1){1'b0}}, 1'b1};
          end
          if (do_push && !do_pop) begin
            cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
          end else if (do_pop && !do_push) begin
            cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
          end
        end
      end
    end
  endgenerate
endmodule // prio_queue_set

// ===== hdl/subnet_pdu_framer_priority.v
// convergence-layer pdu framer: priority queuing, demand builder, accept parser
//
// Overview of operation
// (R1) Elements go out in listed order, each value most significant bit first.
// (R2) Eight priority levels, 7 highest, assigned before anything else.
// (R3) One queue per level; higher levels overtake, order kept within a level.
// (R4) Signalling pdus always queue at fixed priority 4.
// (R5) Data priority above the context maximum is lowered to that maximum.
// (R6) Data request without priority uses the context maximum.
// (R7) Received pdus are parsed in arrival order, no receive queuing.
// (R8) Data payload longer than the transfer unit limit is refused.
// (R9) Network keeps transfer unit below lower-layer unit size.
// (R10) Accept starts with 4,4,3,4,4,4,3-bit mandatory fields.
// (R11) Accept address present only when address type is 1 or 2.
// (R12) Accept slot count present only when compression field lsb is 1.
// (R13) Accept then carries 3-bit unit code and optional elements.
// (R14) Trailing configuration options at most 128 octets; the parser accepts up to 1211 option bits.
// (R15) Demand: 4,4,4,3 bits, cond address, 4, 8, cond 8, options.
// (R16) Demand third 4-bit field never zero.
// (R17) Demand address present only when address type in demand is 0.
// (R18) Demand slot count present only when compression field lsb is 1.
// (R19) Network answers each demand with accept or reject.
// (R20) Optional elements by presence bit; length mismatch marks pdu malformed.
`timescale 1ns/1ps
`include "pdu_framer_defs.vh"
module subnet_pdu_framer_priority #(
  parameter TAG_W   = 8,
  parameter Q_DEPTH = 4,
  parameter Q_AW    = 2
) (
  input  wire             clock_i,
  input  wire             sys_rst_i,
  input  wire [2:0]       reg_addr_i,
  input  wire [31:0]      reg_wdata_i,
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  output wire [31:0]      reg_rdata_o,
  input  wire             tx_req_i,
  input  wire             tx_signalling_i,
  input  wire [3:0]       tx_ctx_i,
  input  wire [2:0]       tx_prio_i,
  input  wire             tx_prio_given_i,
  input  wire [15:0]      tx_len_i,
  input  wire [TAG_W-1:0] tx_tag_i,
  output wire             tx_ack_o,
  output wire             tx_refused_o,
  output wire             q_valid_o,
  output wire [2:0]       q_prio_o,
  output wire [TAG_W-1:0] q_tag_o,
  input  wire             q_ready_i,
  output wire             ser_bit_o,
  output wire             ser_valid_o,
  output wire             ser_last_o,
  input  wire             rx_bit_i,
  input  wire             rx_valid_i,
  input  wire             rx_last_i
);
  // --------------------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------------------
  reg  [31:0]      rdata_reg;
  reg  [30:0]      dem_a_reg;
  reg  [31:0]      dem_ip_reg;
  reg  [21:0]      acc_a_reg;
  reg  [31:0]      acc_ip_reg;
  reg  [18:0]      acc_b_reg;
  reg  [15:0]      mtu_reg;
  reg  [4:0]       status_reg;
  reg              ack_reg;
  reg              refused_reg;
  reg              qv_reg;
  reg  [2:0]       qp_reg;
  reg  [TAG_W-1:0] qt_reg;
  reg              sbit_reg;
  reg              svalid_reg;
  reg              slast_reg;
  reg              dem_busy_reg;
  reg  [3:0]       dem_idx_reg;
  reg  [3:0]       rx_idx_reg;
  reg  [5:0]       rx_cnt_reg;
  reg  [30:0]      rx_sh_reg;
  reg  [10:0]      tail_cnt_reg;
  reg              rx_bad_reg;

  assign reg_rdata_o  = rdata_reg;
  assign tx_ack_o     = ack_reg;
  assign tx_refused_o = refused_reg;
  assign q_valid_o    = qv_reg;
  assign q_prio_o     = qp_reg;
  assign q_tag_o      = qt_reg;
  assign ser_bit_o    = sbit_reg;
  assign ser_valid_o  = svalid_reg;
  assign ser_last_o   = slast_reg;

  // --------------------------------------------------------------------------
  // per-context priority maximum table
  // --------------------------------------------------------------------------
  wire [47:0] pmax_flat;
  wire        rx_ok;
  genvar e;
  generate
    for (e = 0; e < 16; e = e + 1) begin : ctx
      localparam [3:0] CTX = e;
      reg [2:0] pm_reg;
      assign pmax_flat[e*3 +: 3] = pm_reg;
      always @(posedge clock_i) begin
        if (sys_rst_i) begin
          pm_reg <= `PMAX_RST;
        end else if (rx_ok && acc_a_reg[`AA_CTX] == CTX) begin
          pm_reg <= acc_a_reg[`AA_PMAX];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // transmit priority assignment and admission
  // --------------------------------------------------------------------------
  wire [5:0] tab_base = {2'b00, tx_ctx_i} * 6'd3;
  wire [2:0] ctx_max  = pmax_flat[tab_base +: 3];
  reg  [2:0] tx_prio;
  wire       q_full;
  wire       mtu_bad  = !tx_signalling_i && (tx_len_i > mtu_reg); // [R8]
  wire       tx_push  = tx_req_i && !mtu_bad && !q_full;

  always @* begin
    if (tx_signalling_i) begin
      tx_prio = `PRIO_FIXED; // [R4]
    end else if (!tx_prio_given_i) begin
      tx_prio = ctx_max; // [R6]
    end else if (tx_prio_i > ctx_max) begin
      tx_prio = ctx_max; // [R5]
    end else begin
      tx_prio = tx_prio_i; // [R2]
    end
  end

  wire             q_avail;
  wire [2:0]       q_top_prio;
  wire [TAG_W-1:0] q_top_data;
  wire             q_load = q_avail && (!qv_reg || q_ready_i);

  prio_queue_set #(
    .W     (TAG_W),
    .DEPTH (Q_DEPTH),
    .AW    (Q_AW)
  ) u_queues (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .push_i      (tx_push),
    .push_prio_i (tx_prio),
    .push_data_i (tx_tag_i),
    .full_o      (q_full),
    .pop_i       (q_load),
    .avail_o     (q_avail),
    .top_prio_o  (q_top_prio),
    .top_data_o  (q_top_data)
  );

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      ack_reg     <= 1'b0;
      refused_reg <= 1'b0;
      qv_reg      <= 1'b0;
      qp_reg      <= 3'h0;
      qt_reg      <= {TAG_W{1'b0}};
    end else begin
      ack_reg     <= tx_push;
      refused_reg <= tx_req_i && !tx_push;
      if (q_load) begin
        qv_reg <= 1'b1; // [R3]
        qp_reg <= q_top_prio;
        qt_reg <= q_top_data;
      end else if (q_ready_i) begin
        qv_reg <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // demand pdu builder
  // --------------------------------------------------------------------------
  reg  [5:0]  fw;
  reg  [31:0] fv;
  reg         fp;
  wire        ser_free;
  wire        ser_bit;
  wire        ser_valid;
  wire        ser_last;
  wire        dem_load = dem_busy_reg && ser_free && fp;
  wire        dem_start = reg_wr_i && (reg_addr_i == `ADR_CTRL) && reg_wdata_i[`CTRL_START] && !dem_busy_reg;
  wire        dem_zero  = (dem_a_reg[`DA_THIRD] == 4'h0);

  always @* begin
    fw = 6'd4;
    fv = 32'h0;
    fp = 1'b1;
    case (dem_idx_reg) // [R15]
      4'd0: fv = {28'h0, `TYPE_DEMAND};
      4'd1: fv = {28'h0, dem_a_reg[`DA_CTX]};
      4'd2: fv = {28'h0, dem_a_reg[`DA_THIRD]};
      4'd3: begin
        fw = 6'd3;
        fv = {29'h0, dem_a_reg[`DA_ADDRESS_TYPE_IN_DEMAND]};
      end
      4'd4: begin
        fw = 6'd32;
        fv = dem_ip_reg;
        fp = (dem_a_reg[`DA_ADDRESS_TYPE_IN_DEMAND] == 3'h0); // [R17]
      end
      4'd5: fv = {28'h0, dem_a_reg[`DA_SIXTH]};
      4'd6: begin
        fw = 6'd8;
        fv = {24'h0, dem_a_reg[`DA_HCNEG]};
      end
      4'd7: begin
        fw = 6'd8;
        fv = {24'h0, dem_a_reg[`DA_SLOTS]};
        fp = dem_a_reg[15]; // [R18]
      end
      default: begin
        fw = 6'd1;
        fv = 32'h0;
      end
    endcase
  end

  pdu_bit_shifter u_shifter (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .load_i    (dem_load),
    .value_i   (fv),
    .width_i   (fw),
    .last_i    (dem_idx_reg == 4'd8),
    .free_o    (ser_free),
    .bit_o     (ser_bit),
    .valid_o   (ser_valid),
    .last_o    (ser_last)
  );

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      dem_busy_reg <= 1'b0;
      dem_idx_reg  <= 4'h0;
      sbit_reg     <= 1'b0;
      svalid_reg   <= 1'b0;
      slast_reg    <= 1'b0;
    end else begin
      sbit_reg   <= ser_bit;
      svalid_reg <= ser_valid;
      slast_reg  <= ser_last;
      if (dem_start && !dem_zero) begin
        dem_busy_reg <= 1'b1; // [R16]
        dem_idx_reg  <= 4'h0;
      end else if (dem_busy_reg && ser_free) begin
        if (dem_idx_reg == 4'd8) begin
          dem_busy_reg <= 1'b0;
        end
        dem_idx_reg <= dem_idx_reg + 4'd1; // [R1]
      end
    end
  end

  // --------------------------------------------------------------------------
  // accept pdu parser
  // --------------------------------------------------------------------------
  wire [31:0] rx_word = {rx_sh_reg, rx_bit_i};
  wire        rx_done = rx_valid_i && (rx_idx_reg <= 4'd11) && (rx_cnt_reg == 6'd1);
  wire        rx_end  = rx_valid_i && rx_last_i;
  reg  [3:0]  rx_nxt;
  reg  [5:0]  rx_nw;

  always @* begin
    rx_nxt = rx_idx_reg + 4'd1; // [R10]
    if (rx_idx_reg == 4'd0 && rx_word[3:0] != `TYPE_ACCEPT) begin
      rx_nxt = 4'd14;
    end else if (rx_idx_reg == 4'd6 && rx_word[2:0] != 3'h1 && rx_word[2:0] != 3'h2) begin
      rx_nxt = 4'd8; // [R11]
    end else if (rx_idx_reg == 4'd8 && !rx_word[0]) begin
      rx_nxt = 4'd10; // [R12]
    end else if (rx_idx_reg == 4'd11) begin
      rx_nxt = rx_word[0] ? 4'd12 : 4'd13; // [R20]
    end
    case (rx_nxt)
      4'd2, 4'd6, 4'd10: rx_nw = 6'd3; // [R13]
      4'd7: rx_nw = 6'd32;
      4'd8, 4'd9: rx_nw = 6'd8;
      4'd11: rx_nw = 6'd1;
      default: rx_nw = 6'd4;
    endcase
  end

  wire rx_ignore = (rx_idx_reg == 4'd14) || (rx_done && rx_nxt == 4'd14);
  wire rx_shape  = (rx_done && rx_idx_reg == 4'd11 && !rx_bit_i) || (rx_idx_reg == 4'd12);
  wire rx_tail_over = (rx_idx_reg == 4'd12) && (tail_cnt_reg == `OPT_MAX_BITS);
  assign rx_ok = rx_end && !rx_ignore && !rx_bad_reg && !rx_tail_over && rx_shape;
  wire rx_mal  = rx_end && !rx_ignore && !rx_ok; // [R20]

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      rx_idx_reg   <= 4'h0;
      rx_cnt_reg   <= 6'd4;
      rx_sh_reg    <= 31'h0;
      tail_cnt_reg <= 11'h0;
      rx_bad_reg   <= 1'b0;
      acc_a_reg    <= 22'h0;
      acc_ip_reg   <= 32'h0;
      acc_b_reg    <= 19'h0;
    end else if (rx_valid_i) begin
      rx_sh_reg <= rx_word[30:0]; // [R7]
      if (rx_done) begin
        case (rx_idx_reg)
          4'd1: acc_a_reg[`AA_CTX] <= rx_word[3:0];
          4'd2: acc_a_reg[`AA_PMAX] <= rx_word[2:0];
          4'd3: acc_a_reg[`AA_READY] <= rx_word[3:0];
          4'd4: acc_a_reg[`AA_STBY] <= rx_word[3:0];
          4'd5: acc_a_reg[`AA_RWAIT] <= rx_word[3:0];
          4'd6: acc_a_reg[`AA_TIA] <= rx_word[2:0];
          4'd7: acc_ip_reg <= rx_word;
          4'd8: acc_b_reg[`AB_HCNEG] <= rx_word[7:0];
          4'd9: acc_b_reg[`AB_SLOTS] <= rx_word[7:0];
          4'd10: acc_b_reg[`AB_MTU] <= rx_word[2:0];
          default: acc_b_reg <= acc_b_reg;
        endcase
      end
      if (rx_end) begin
        rx_idx_reg   <= 4'h0;
        rx_cnt_reg   <= 6'd4;
        tail_cnt_reg <= 11'h0;
        rx_bad_reg   <= 1'b0;
      end else if (rx_done) begin
        rx_idx_reg <= rx_nxt;
        rx_cnt_reg <= rx_nw;
      end else if (rx_idx_reg == 4'd12) begin
        tail_cnt_reg <= tail_cnt_reg + 11'h1; // [R14]
        if (rx_tail_over) begin
          rx_bad_reg <= 1'b1;
        end
      end else if (rx_idx_reg == 4'd13) begin
        rx_bad_reg <= 1'b1;
      end else if (rx_idx_reg <= 4'd11) begin
        rx_cnt_reg <= rx_cnt_reg - 6'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // register port
  // --------------------------------------------------------------------------
  wire       st_wr  = reg_wr_i && (reg_addr_i == `ADR_STATUS);
  wire [4:0] st_set = {tx_req_i && !mtu_bad && q_full,
                       dem_start && dem_zero,
                       tx_req_i && mtu_bad,
                       rx_mal,
                       rx_ok};

  always @(posedge clock_i) begin
    if (sys_rst_i) begin
      dem_a_reg  <= 31'h0;
      dem_ip_reg <= 32'h0;
      mtu_reg    <= `MTU_RST;
      status_reg <= 5'h0;
      rdata_reg  <= 32'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `ADR_DEMAND_A) begin
        dem_a_reg <= reg_wdata_i[30:0];
      end else if (reg_wr_i && reg_addr_i == `ADR_DEMAND_IP) begin
        dem_ip_reg <= reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == `ADR_MTU) begin
        mtu_reg <= reg_wdata_i[15:0];
      end
      status_reg <= st_set | (status_reg & ~(st_wr ? reg_wdata_i[4:0] : 5'h0));
      if (!reg_rd_i) begin
        rdata_reg <= 32'h0;
      end else if (reg_addr_i == `ADR_DEMAND_A) begin
        rdata_reg <= {1'b0, dem_a_reg};
      end else if (reg_addr_i == `ADR_DEMAND_IP) begin
        rdata_reg <= dem_ip_reg;
      end else if (reg_addr_i == `ADR_STATUS) begin
        rdata_reg <= {23'h0, dem_busy_reg, 3'h0, status_reg};
      end else if (reg_addr_i == `ADR_ACCEPT_A) begin
        rdata_reg <= {10'h0, acc_a_reg};
      end else if (reg_addr_i == `ADR_ACCEPT_IP) begin
        rdata_reg <= acc_ip_reg;
      end else if (reg_addr_i == `ADR_ACCEPT_B) begin
        rdata_reg <= {13'h0, acc_b_reg};
      end else if (reg_addr_i == `ADR_MTU) begin
        rdata_reg <= {16'h0, mtu_reg};
      end else begin
        rdata_reg <= 32'h0;
      end
    end
  end
endmodule // subnet_pdu_framer_priority

// ===== tb/lower_link_model.sv
// lower link layer model: drains the priority head, stalls on demand
`timescale 1ns/1ps
module lower_link_model #(
  parameter TAG_W = 8
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             stall_i,
  input  wire logic             q_valid_i,
  input  wire logic [2:0]       q_prio_i,
  input  wire logic [TAG_W-1:0] q_tag_i,
  output logic                  q_ready_o,
  output wire logic             pop_o,
  output wire logic [TAG_W+2:0] pop_item_o
);
  // ----
  // mirrored queue entry: takes heads in offered order, randomly slow
  // ----
  always @(posedge clock_i) begin
    q_ready_o <= !sys_rst_i && !stall_i && ($urandom_range(1, 0) == 1);
  end
  assign pop_o      = q_valid_i && q_ready_o;
  assign pop_item_o = {q_prio_i, q_tag_i};
endmodule // lower_link_model

// ===== tb/subnet_pdu_framer_priority_checker.sv
// port-level assertions of the pdu framer
`timescale 1ns/1ps
`include "pdu_framer_defs.vh"
module pdu_framer_checker #(
  parameter TAG_W = 8
) (
  input wire logic             clock_i,
  input wire logic             sys_rst_i,
  input wire logic [2:0]       reg_addr_i,
  input wire logic [31:0]      reg_wdata_i,
  input wire logic             reg_wr_i,
  input wire logic             reg_rd_i,
  input wire logic [31:0]      reg_rdata_o,
  input wire logic             tx_req_i,
  input wire logic             tx_signalling_i,
  input wire logic [15:0]      tx_len_i,
  input wire logic             tx_ack_o,
  input wire logic             tx_refused_o,
  input wire logic             q_valid_o,
  input wire logic [2:0]       q_prio_o,
  input wire logic [TAG_W-1:0] q_tag_o,
  input wire logic             q_ready_i,
  input wire logic             ser_bit_o,
  input wire logic             ser_valid_o,
  input wire logic             ser_last_o
);
  // ----
  // helpers: unit limit mirror, bit count within a frame
  // ----
  logic [15:0] mtu_reg;
  logic [6:0]  cnt_reg;
  logic [6:0]  cnt_next;
  assign cnt_next = !ser_valid_o ? cnt_reg : (ser_last_o ? 7'h00 : cnt_reg + 7'h01);
  always @(posedge clock_i) begin
    mtu_reg <= sys_rst_i ? `MTU_RST : ((reg_wr_i && reg_addr_i == `ADR_MTU) ? reg_wdata_i[15:0] : mtu_reg);
    cnt_reg <= sys_rst_i ? 7'h00 : cnt_next;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // ----
  // assertions
  // ----
  a_req_answer: assert property (tx_req_i |=> tx_ack_o != tx_refused_o)
    else $error("not one answer");
  a_no_spur_ans: assert property (!tx_req_i |=> !tx_ack_o && !tx_refused_o)
    else $error("answer without request");
  a_big_refused: assert property (tx_req_i && !tx_signalling_i && tx_len_i > mtu_reg |=> tx_refused_o)
    else $error("oversize not refused");
  a_head_hold: assert property (q_valid_o && !q_ready_i |=> q_valid_o && $stable(q_prio_o) && $stable(q_tag_o))
    else $error("queue head changed before acceptance");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("stray read data");
  a_last_obit: assert property (ser_last_o |-> ser_valid_o && !ser_bit_o)
    else $error("bad frame end");
  a_frame_type: assert property (ser_valid_o && cnt_reg < 7'h04 |-> !ser_bit_o)
    else $error("demand type code bit wrong");
  a_frame_len: assert property (ser_valid_o && ser_last_o |-> cnt_reg inside {7'd27, 7'd35, 7'd59, 7'd67})
    else $error("demand frame length impossible");
  c_refused: cover property (tx_refused_o);
  c_frame: cover property (ser_last_o);
  c_stall: cover property (q_valid_o && !q_ready_i);
endmodule // pdu_framer_checker

bind subnet_pdu_framer_priority pdu_framer_checker #(.TAG_W(TAG_W)) chk_u (.*);

// ===== tb/subnet_pdu_framer_priority_tb.sv
// self-checking bench of the pdu framer
`timescale 1ns/1ps
`include "pdu_framer_defs.vh"
module subnet_pdu_framer_priority_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, req = 0, sig = 0, given = 0, rxb = 0, rxv = 0, rxl = 0, stall = 1;
  logic [2:0] adr = 0, prio = 0, pm [16] = '{default: 0};
  logic [31:0] wd = 0, rdat;
  logic [15:0] len = 0, mtu = 16'h05dc;
  logic [3:0] ctx = 0;
  logic [7:0] tag = 0;
  logic ack, refd, qv, qr, sb, sv, sl, pop;
  logic [2:0] qp;
  logic [7:0] qt;
  logic [10:0] item, expq [$];
  logic sbits [$];
  logic [127:0] bv;
  int bn, cnt [8], n_errors = 0, total_checks = 0, cyc = 0;

  subnet_pdu_framer_priority dut_u (.clock_i(clk), .sys_rst_i(rst), .reg_addr_i(adr), .reg_wdata_i(wd),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .tx_req_i(req), .tx_signalling_i(sig), .tx_ctx_i(ctx),
    .tx_prio_i(prio), .tx_prio_given_i(given), .tx_len_i(len), .tx_tag_i(tag), .tx_ack_o(ack),
    .tx_refused_o(refd), .q_valid_o(qv), .q_prio_o(qp), .q_tag_o(qt), .q_ready_i(qr), .ser_bit_o(sb),
    .ser_valid_o(sv), .ser_last_o(sl), .rx_bit_i(rxb), .rx_valid_i(rxv), .rx_last_i(rxl));
  lower_link_model link_u (.clock_i(clk), .sys_rst_i(rst), .stall_i(stall), .q_valid_i(qv), .q_prio_i(qp),
    .q_tag_i(qt), .q_ready_o(qr), .pop_o(pop), .pop_item_o(item));

  // ----
  // clock, watchdog, monitors
  // ----
  always #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 30000) begin n_errors++; conclude(); end
  always @(posedge clk) if (sv) sbits.push_back(sb);
  always @(posedge clk) if (pop) chk(item, expq.pop_front());

  function automatic logic [2:0] ep(input logic s, g, input logic [2:0] p, m);
    return s ? `PRIO_FIXED : ((!g || p > m) ? m : p);
  endfunction

  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----
  // bus, request and frame tasks
  // ----
  task automatic wrt(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk); adr <= a; wd <= d; wr <= 1;
    @(posedge clk); wr <= 0;
    if (a == `ADR_MTU) mtu = d[15:0];
  endtask
  task automatic rdc(input logic [2:0] a, input logic [31:0] e);
    @(posedge clk); adr <= a; rd <= 1;
    @(posedge clk); rd <= 0;
    #1 chk(rdat, e);
  endtask
  task automatic send(input logic s, g, input logic [3:0] c, input logic [2:0] p, input logic [15:0] l);
    logic ok; logic [2:0] e; int i;
    e = ep(s, g, p, pm[c]);
    ok = (s || l <= mtu) && cnt[e] < 4;
    @(posedge clk); sig <= s; given <= g; ctx <= c; prio <= p; len <= l; tag <= tag + 1; req <= 1;
    @(posedge clk); req <= 0;
    #1 chk({ack, refd}, {ok, !ok});
    if (ok && expq.size() == 0) expq.push_back({e, tag});
    else if (ok) begin
      cnt[e]++;
      for (i = 1; i < expq.size() && expq[i][10:8] >= e; i++);
      expq.insert(i, {e, tag});
    end
  endtask
  task automatic drain;
    stall <= 0;
    for (int i = 0; i < 300 && expq.size() > 0; i++) @(posedge clk);
    chk(expq.size(), 0);
    stall <= 1;
    cnt = '{default: 0};
    repeat (3) @(posedge clk);
  endtask
  task automatic put(input logic [31:0] x, input int w);
    for (int i = w - 1; i >= 0; i--) begin bv = {bv[126:0], x[i]}; bn++; end
  endtask
  task automatic acc(input logic [3:0] c, input logic [2:0] p, t, input logic skip);
    logic [11:0] tm; logic [7:0] ng;
    tm = $urandom; ng = $urandom; bn = 0;
    put(`TYPE_ACCEPT, 4); put(c, 4); put(p, 3); put(tm, 12); put(t, 3);
    if ((t == 1 || t == 2) && !skip) put($urandom, 32);
    put(ng, 8); if (ng[0]) put($urandom, 8);
    put($urandom, 3); put(0, 1);
    wrt(`ADR_STATUS, 32'h1f);
    for (int i = bn - 1; i >= 0; i--) begin @(posedge clk); rxb <= bv[i]; rxv <= 1; rxl <= (i == 0); end
    @(posedge clk); rxv <= 0; rxl <= 0;
    rdc(`ADR_STATUS, skip ? 32'h2 : 32'h1);
    if (!skip) begin pm[c] = p; rdc(`ADR_ACCEPT_A, {t, tm[3:0], tm[7:4], tm[11:8], p, c}); end
  endtask
  task automatic dem(input logic [3:0] th, input logic [2:0] at, input logic [7:0] ng);
    logic [3:0] c, sx; logic [7:0] slots; logic [31:0] ip;
    c = $urandom; sx = $urandom; slots = $urandom; ip = $urandom; bn = 0;
    put(`TYPE_DEMAND, 4); put(c, 4); put(th, 4); put(at, 3);
    if (at == 0) put(ip, 32);
    put(sx, 4); put(ng, 8); if (ng[0]) put(slots, 8);
    put(0, 1);
    wrt(`ADR_STATUS, 32'h1f);
    wrt(`ADR_DEMAND_A, {1'b0, slots, ng, sx, at, th, c});
    wrt(`ADR_DEMAND_IP, ip);
    sbits = {};
    wrt(`ADR_CTRL, 32'h1);
    for (int i = 0; i < 120 && !sl; i++) @(posedge clk) #1;
    @(posedge clk) #1;
    chk(sbits.size(), th == 0 ? 0 : bn);
    for (int i = 0; i < sbits.size(); i++) chk(sbits[i], bv[bn - 1 - i]);
    rdc(`ADR_STATUS, th == 0 ? 32'h8 : 32'h0);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(51));
    repeat (2) @(posedge clk);
    rst <= 0;
    rdc(`ADR_MTU, 32'h5dc);
    wrt(`ADR_ACCEPT_A, 32'hffffffff);
    rdc(`ADR_ACCEPT_A, 32'h0);
    send(0, 1, 4'h3, 3'h7, 16'h000a);
    send(1, 1, 4'h3, 3'h1, 16'h000a);
    drain();
    for (int k = 0; k < 4; k++) acc($urandom_range(7, 0), $urandom_range(6, 1), k, 0);
    acc(4'hf, 3'h5, 3'h1, 1);
    repeat (3) begin
      repeat (10) send($urandom_range(1, 0), $urandom_range(1, 0), $urandom_range(7, 0), $urandom,
                       $urandom_range(1600, 1400));
      drain();
    end
    wrt(`ADR_STATUS, 32'h1f);
    send(0, 1, 4'h0, 3'h0, 16'h0001);
    repeat (5) send(1, 0, 4'h0, 3'h0, 16'h0001);
    rdc(`ADR_STATUS, 32'h10);
    drain();
    wrt(`ADR_MTU, 32'h64);
    wrt(`ADR_STATUS, 32'h1f);
    send(0, 0, 4'h1, 3'h0, 16'h0064);
    send(0, 0, 4'h1, 3'h0, 16'h0065);
    send(1, 0, 4'h1, 3'h0, 16'h00c8);
    rdc(`ADR_STATUS, 32'h4);
    drain();
    for (int k = 0; k < 4; k++) dem($urandom_range(15, 1), k[0] ? $urandom_range(7, 1) : 0,
                                   {$urandom_range(127, 0), k[1]});
    dem(4'h0, 3'h0, 8'h00);
    conclude();
  end
endmodule // subnet_pdu_framer_priority_tb
